//--- src/idv_pkg.sv
/*
 * idv_pkg: register map, field layout, reset values, ramp timing and
 * datapath constants for the input digital volume ramp block.
 * Assumes a 125 MHz core clock and three input paths.
 */
package idv_pkg;

	// register offsets
	localparam logic [15:0] ADDR_RAMP_RATES = 16'h0309;
	localparam logic [15:0] ADDR_PATH1L     = 16'h0311;
	localparam logic [15:0] ADDR_PATH1R     = 16'h0315;
	localparam logic [15:0] ADDR_PATH2      = 16'h0319;

	// field positions
	localparam int APPLY_BIT   = 9;
	localparam int SILENCE_BIT = 8;
	localparam int FALL_LSB    = 4;
	localparam int RISE_LSB    = 0;
	localparam int RATE_W      = 3;
	localparam int CODE_W      = 8;

	// reset values and code limits
	localparam logic [2:0] RATE_RESET    = 3'h2;
	localparam logic [7:0] CODE_RESET    = 8'h80;
	localparam logic       SILENCE_RESET = 1'b1;
	localparam logic [7:0] CODE_MAX      = 8'hBF;

	// gain in fine steps of 0.125 dB, index 0 = -64 dB
	localparam int GAIN_W        = 10;
	localparam int FINE_PER_CODE = 4;
	localparam int FINE_PER_6DB  = 48;
	localparam int UNITY_OFS     = 16;
	localparam int UNITY_OCT     = 11;
	localparam int HEADROOM_SH   = 1;

	// 2^x mantissa approximation, Q16
	localparam int MANT_ONE    = 65536;
	localparam int MANT_C1     = 43024;
	localparam int MANT_C2     = 22512;
	localparam int FRAC_RECIP  = 1365;

	// ramp rates as time per 6 dB, in microseconds
	localparam int CLK_MHZ     = 125;
	localparam int RATE_US_0P5 = 500;
	localparam int RATE_US_1   = 1000;
	localparam int RATE_US_2   = 2000;
	localparam int RATE_US_4   = 4000;
	localparam int RATE_US_8   = 8000;
	localparam int RATE_US_15  = 15000;
	localparam int RATE_US_30  = 30000;
	localparam int STEP_CYC_0P5 = RATE_US_0P5 * CLK_MHZ / FINE_PER_6DB;
	localparam int STEP_CYC_1   = RATE_US_1 * CLK_MHZ / FINE_PER_6DB;
	localparam int STEP_CYC_2   = RATE_US_2 * CLK_MHZ / FINE_PER_6DB;
	localparam int STEP_CYC_4   = RATE_US_4 * CLK_MHZ / FINE_PER_6DB;
	localparam int STEP_CYC_8   = RATE_US_8 * CLK_MHZ / FINE_PER_6DB;
	localparam int STEP_CYC_15  = RATE_US_15 * CLK_MHZ / FINE_PER_6DB;
	localparam int STEP_CYC_30  = RATE_US_30 * CLK_MHZ / FINE_PER_6DB;
	localparam int TIMER_W      = 17;

	// datapath
	localparam int NUM_PATHS  = 3;
	localparam int SAMPLE_W   = 24;
	localparam int PATH_W     = 2;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [1:0] {
		RAMP_HOLD = 2'b00,
		RAMP_RISE = 2'b01,
		RAMP_FALL = 2'b10
	} idv_ramp_t;

endpackage

//--- src/idv_fifo.sv
/*
 * idv_fifo: flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module idv_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	wire              push;
	wire              pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- src/idv_gain_scale.sv
/*
 * idv_gain_scale: one-stage multiplier applying a fine-step gain index
 * to a sample, with headroom shift and saturation.
 * Assumes the gain index is stable while in_valid is high.
 */
`timescale 1ns/1ns
module idv_gain_scale
	import idv_pkg::*;
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                srst,
	// sample in
	input  wire logic                in_valid,
	output logic                     in_ready,
	input  wire logic [PATH_W-1:0]   in_path,
	input  wire logic [SAMPLE_W-1:0] in_sample,
	input  wire logic [GAIN_W-1:0]   in_fine,
	input  wire logic                in_silent,
	// sample out
	output logic                     out_valid,
	input  wire logic                out_ready,
	output logic [PATH_W-1:0]        out_path,
	output logic [SAMPLE_W-1:0]      out_sample
);
	localparam int PROD_W = SAMPLE_W + 18;
	localparam int WIDE_W = PROD_W + 16;
	localparam int OUT_SH = 16 + UNITY_OCT - HEADROOM_SH;

	// quadratic 2^(frac/48), error well under a fine step
	function automatic logic [16:0] mantissa(input logic [5:0] frac);
		logic [33:0] x;
		logic [33:0] inner;
		logic [33:0] outer;
		x     = 34'(frac) * 34'(FRAC_RECIP);
		inner = 34'(MANT_C1) + ((34'(MANT_C2) * x) >> 16);
		outer = 34'(MANT_ONE) + ((x * inner) >> 16);
		return outer[16:0];
	endfunction

	wire [GAIN_W:0]             shifted_idx;
	wire [4:0]                  oct;
	wire [5:0]                  frac;
	wire signed [PROD_W-1:0]    prod;
	wire signed [WIDE_W-1:0]    wide;
	wire signed [WIDE_W-1:0]    scaled;
	wire                        too_high;
	wire                        too_low;
	wire [SAMPLE_W-1:0]         sat;
	localparam logic signed [WIDE_W-1:0] POS_MAX =
		WIDE_W'((64'(1) << (SAMPLE_W-1)) - 1);
	localparam logic signed [WIDE_W-1:0] NEG_MAX = -POS_MAX - 1;

	assign in_ready    = !out_valid || out_ready;
	assign shifted_idx = (GAIN_W+1)'(in_fine) + (GAIN_W+1)'(UNITY_OFS);
	assign oct  = 5'(shifted_idx / (GAIN_W+1)'(FINE_PER_6DB));
	assign frac = 6'(shifted_idx % (GAIN_W+1)'(FINE_PER_6DB));
	assign prod = PROD_W'($signed(in_sample))
		* PROD_W'($signed({1'b0, mantissa(frac)}));
	assign wide   = WIDE_W'(prod) <<< oct;
	// unity gain doubles the input level
	assign scaled   = wide >>> OUT_SH;
	assign too_high = scaled > POS_MAX;
	assign too_low  = scaled < NEG_MAX;
	assign sat = too_high ? POS_MAX[SAMPLE_W-1:0] :
		too_low ? NEG_MAX[SAMPLE_W-1:0] : scaled[SAMPLE_W-1:0];

	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid  <= 1'b0;
			out_path   <= '0;
			out_sample <= '0;
		end else if (in_ready) begin
			out_valid  <= in_valid;
			out_path   <= in_path;
			out_sample <= in_silent ? '0 : sat;
		end
	end
endmodule

//--- src/idv_top.sv
/*
 * idv_top: digital gain and silence stage for three input paths, with
 * double-buffered settings, a shared apply strobe and rate-controlled
 * gain ramps in 0.125 dB steps; samples pass through a 32-word FIFO.
 * Assumes register accesses and samples are synchronous to CORE_CLK.
 */
// Function
// - gain -64 dB to +31.5 dB, 0.5 dB steps
// - silence bit 8, 1 mutes, resets muted
// - rising gain or unmute ramps at rise rate
// - falling gain or mute ramps at fall rate
// - rate codes 0 to 30 ms per 6 dB
// - write without apply bit only stores
// - apply bit updates all paths together
// - ramps move in 0.125 dB fine steps
// - code 80h is 0 dB, reserved above BFh
// - unity gain maps -6 dBFS to full scale
`timescale 1ns/1ns
module idv_top
	import idv_pkg::*;
#(
	parameter int P_STEP_CYC_2  = STEP_CYC_2,
	parameter int P_STEP_CYC_4  = STEP_CYC_4,
	parameter int P_STEP_CYC_8  = STEP_CYC_8,
	parameter int P_STEP_CYC_15 = STEP_CYC_15,
	parameter int P_STEP_CYC_30 = STEP_CYC_30
) (
	// clock and reset
	input  wire logic                CORE_CLK,
	input  wire logic                SRST,
	// register access
	input  wire logic                REG_WR_EN,
	input  wire logic                REG_RD_EN,
	input  wire logic [15:0]         REG_ADDR,
	input  wire logic [15:0]         REG_WR_DATA,
	output logic [15:0]              REG_RD_DATA,
	output logic                     REG_RD_VALID,
	// sample input
	input  wire logic                IN_VALID,
	output logic                     IN_READY,
	input  wire logic [PATH_W-1:0]   IN_PATH,
	input  wire logic [SAMPLE_W-1:0] IN_SAMPLE,
	// sample output
	output logic                     OUT_VALID,
	input  wire logic                OUT_READY,
	output logic [PATH_W-1:0]        OUT_PATH,
	output logic [SAMPLE_W-1:0]      OUT_SAMPLE,
	// status
	output logic [NUM_PATHS-1:0]     RAMP_BUSY
);
	localparam int FIFO_W = PATH_W + SAMPLE_W;

	// stored settings
	logic [RATE_W-1:0] gain_rise_rate_reg;
	logic [RATE_W-1:0] gain_fall_rate_reg;
	logic [CODE_W-1:0] gain_code_reg    [NUM_PATHS];
	logic              silence_reg      [NUM_PATHS];
	// applied state
	logic [GAIN_W-1:0] target_reg       [NUM_PATHS];
	logic              app_silence_reg  [NUM_PATHS];
	logic [GAIN_W-1:0] cur_reg          [NUM_PATHS];
	logic [GAIN_W-1:0] cur_next         [NUM_PATHS];
	// step timers
	logic [TIMER_W-1:0] rise_cnt_reg;
	logic [TIMER_W-1:0] fall_cnt_reg;

	function automatic logic [15:0] path_addr(input int idx);
		case (idx)
			0:       return ADDR_PATH1L;
			1:       return ADDR_PATH1R;
			default: return ADDR_PATH2;
		endcase
	endfunction

	// stored code keeps reserved values; only the gain clamps
	// reserved codes clamp to the top code
	// code in half-dB maps to fine steps
	function automatic logic [GAIN_W-1:0] target_of(
		input logic [CODE_W-1:0] code,
		input logic              silent
	);
		logic [CODE_W-1:0] lim;
		lim = (code > CODE_MAX) ? CODE_MAX : code;
		if (silent)
			return '0;
		return GAIN_W'(lim) * GAIN_W'(FINE_PER_CODE);
	endfunction

	// rise and fall may run at once on different paths
	function automatic idv_ramp_t ramp_dir(
		input logic [GAIN_W-1:0] cur,
		input logic [GAIN_W-1:0] tgt
	);
		idv_ramp_t d;
		case ({cur < tgt, cur > tgt})
			2'b10:   d = RAMP_RISE;
			2'b01:   d = RAMP_FALL;
			default: d = RAMP_HOLD;
		endcase
		return d;
	endfunction

	// rate code to cycles per fine step
	// interval is time per 6 dB over 48
	function automatic logic [TIMER_W-1:0] step_cycles(
		input logic [RATE_W-1:0] rate
	);
		case (rate)
			3'h1:    return TIMER_W'(STEP_CYC_0P5);
			3'h2:    return TIMER_W'(STEP_CYC_1);
			3'h3:    return TIMER_W'(P_STEP_CYC_2);
			3'h4:    return TIMER_W'(P_STEP_CYC_4);
			3'h5:    return TIMER_W'(P_STEP_CYC_8);
			3'h6:    return TIMER_W'(P_STEP_CYC_15);
			3'h7:    return TIMER_W'(P_STEP_CYC_30);
			default: return TIMER_W'(1);
		endcase
	endfunction

	// register decode
	wire                 wr_rates;
	wire [NUM_PATHS-1:0] wr_path;
	wire [NUM_PATHS-1:0] rd_path;
	wire                 rd_rates;
	wire                 apply;
	wire [NUM_PATHS-1:0] rising;
	wire [NUM_PATHS-1:0] falling;
	wire                 rise_any;
	wire                 fall_any;
	wire                 rise_jump;
	wire                 fall_jump;
	wire [TIMER_W-1:0]   rise_lim;
	wire [TIMER_W-1:0]   fall_lim;
	wire                 rise_tick;
	wire                 fall_tick;
	logic [15:0]         rd_word;
	wire [CODE_W-1:0]    wr_code;
	wire                 wr_silence;

	assign wr_rates = REG_WR_EN && (REG_ADDR == ADDR_RAMP_RATES);
	assign rd_rates = REG_RD_EN && (REG_ADDR == ADDR_RAMP_RATES);
	// write fields shared by store and apply
	assign wr_code    = REG_WR_DATA[CODE_W-1:0];
	assign wr_silence = REG_WR_DATA[SILENCE_BIT];

	genvar g;
	generate
		for (g = 0; g < NUM_PATHS; g++) begin : g_path
			assign wr_path[g] = REG_WR_EN && (REG_ADDR == path_addr(g));
			assign rd_path[g] = REG_RD_EN && (REG_ADDR == path_addr(g));
			assign rising[g]  = ramp_dir(cur_reg[g], target_reg[g])
				== RAMP_RISE;
			assign falling[g] = ramp_dir(cur_reg[g], target_reg[g])
				== RAMP_FALL;
			assign RAMP_BUSY[g] = rising[g] || falling[g];
		end
	endgenerate

	// the apply bit itself is never stored
	// apply bit in any path register loads every path
	assign apply = (|wr_path) && REG_WR_DATA[APPLY_BIT];

	assign rise_any  = |rising;
	assign fall_any  = |falling;
	assign rise_jump = (gain_rise_rate_reg == '0);
	assign fall_jump = (gain_fall_rate_reg == '0);
	assign rise_lim  = step_cycles(gain_rise_rate_reg);
	assign fall_lim  = step_cycles(gain_fall_rate_reg);
	// one tick per elapsed interval
	// >= so a rate cut mid-ramp cannot stall a timer
	assign rise_tick = rise_any && (rise_cnt_reg >= rise_lim - 1'b1);
	assign fall_tick = fall_any && (fall_cnt_reg >= fall_lim - 1'b1);

	// read mux; apply bit always reads back as zero
	always_comb begin
		rd_word = 16'h0000;
		if (rd_rates) begin
			rd_word[FALL_LSB +: RATE_W] = gain_fall_rate_reg;
			rd_word[RISE_LSB +: RATE_W] = gain_rise_rate_reg;
		end
		for (int i = 0; i < NUM_PATHS; i++) begin
			if (rd_path[i]) begin
				rd_word[SILENCE_BIT]  = silence_reg[i];
				rd_word[CODE_W-1:0]   = gain_code_reg[i];
			end
		end
	end

	// applied gain moves one fine step per tick, or straight to target at rate code 0
	always_comb begin
		for (int i = 0; i < NUM_PATHS; i++) begin
			cur_next[i] = cur_reg[i];
			// rise toward target at rise rate
			if (rising[i]) begin
				if (rise_jump)
					cur_next[i] = target_reg[i];
				else if (rise_tick)
					cur_next[i] = cur_reg[i] + 1'b1;
			end
			// fall toward target at fall rate
			if (falling[i]) begin
				if (fall_jump)
					cur_next[i] = target_reg[i];
				else if (fall_tick)
					cur_next[i] = cur_reg[i] - 1'b1;
			end
		end
	end

	// rate register; software keeps it still during a ramp
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			gain_rise_rate_reg <= RATE_RESET;
			gain_fall_rate_reg <= RATE_RESET;
		end else if (wr_rates) begin
			gain_rise_rate_reg <= REG_WR_DATA[RISE_LSB +: RATE_W];
			gain_fall_rate_reg <= REG_WR_DATA[FALL_LSB +: RATE_W];
		end
	end

	// path writes only store the setting
	always_ff @(posedge CORE_CLK) begin
		for (int i = 0; i < NUM_PATHS; i++) begin
			if (SRST) begin
				gain_code_reg[i] <= CODE_RESET;
				silence_reg[i]   <= SILENCE_RESET;
			end else if (wr_path[i]) begin
				gain_code_reg[i] <= wr_code;
				silence_reg[i]   <= wr_silence;
			end
		end
	end

	// targets take the stored settings, the write's own included
	always_ff @(posedge CORE_CLK) begin
		for (int i = 0; i < NUM_PATHS; i++) begin
			if (SRST) begin
				target_reg[i]      <= target_of(CODE_RESET, SILENCE_RESET);
				app_silence_reg[i] <= SILENCE_RESET;
			end else if (apply) begin
				target_reg[i] <= wr_path[i] ?
					target_of(wr_code, wr_silence) :
					target_of(gain_code_reg[i], silence_reg[i]);
				app_silence_reg[i] <= wr_path[i] ?
					wr_silence : silence_reg[i];
			end
		end
	end

	// reset starts muted at the floor, so no ramp runs out of reset
	always_ff @(posedge CORE_CLK) begin
		for (int i = 0; i < NUM_PATHS; i++) begin
			if (SRST)
				cur_reg[i] <= '0;
			else
				cur_reg[i] <= cur_next[i];
		end
	end

	// timers restart whenever no path ramps their way
	always_ff @(posedge CORE_CLK) begin
		if (SRST || !rise_any || rise_tick)
			rise_cnt_reg <= '0;
		else
			rise_cnt_reg <= rise_cnt_reg + 1'b1;
	end

	// one shared timer per direction keeps paths in step
	always_ff @(posedge CORE_CLK) begin
		if (SRST || !fall_any || fall_tick)
			fall_cnt_reg <= '0;
		else
			fall_cnt_reg <= fall_cnt_reg + 1'b1;
	end

	// read data registered; zero between reads
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			REG_RD_DATA  <= 16'h0000;
			REG_RD_VALID <= 1'b0;
		end else begin
			REG_RD_DATA  <= rd_word;
			REG_RD_VALID <= REG_RD_EN;
		end
	end

	// sample path: fifo then gain stage
	wire                fifo_valid;
	wire                fifo_ready;
	wire [FIFO_W-1:0]   fifo_data;
	wire [PATH_W-1:0]   head_path;
	wire                head_known;
	logic [GAIN_W-1:0]  head_fine;
	logic               head_silent;

	// tag 3 names no path and is always silent
	assign head_path  = fifo_data[FIFO_W-1 -: PATH_W];
	assign head_known = (head_path < PATH_W'(NUM_PATHS));

	// silent only once a muted path has ramped to the floor
	always_comb begin
		head_fine   = '0;
		head_silent = 1'b1;
		for (int i = 0; i < NUM_PATHS; i++) begin
			if (head_known && (head_path == PATH_W'(i))) begin
				head_fine   = cur_reg[i];
				head_silent = app_silence_reg[i] && (cur_reg[i] == '0);
			end
		end
	end

	// fifo absorbs bursts while the sink stalls
	idv_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CORE_CLK),
		.srst      (SRST),
		.in_valid  (IN_VALID),
		.in_ready  (IN_READY),
		.in_data   ({IN_PATH, IN_SAMPLE}),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	idv_gain_scale u_scale (
		.clk        (CORE_CLK),
		.srst       (SRST),
		.in_valid   (fifo_valid),
		.in_ready   (fifo_ready),
		.in_path    (head_path),
		.in_sample  (fifo_data[SAMPLE_W-1:0]),
		.in_fine    (head_fine),
		.in_silent  (head_silent),
		.out_valid  (OUT_VALID),
		.out_ready  (OUT_READY),
		.out_path   (OUT_PATH),
		.out_sample (OUT_SAMPLE)
	);
endmodule

//--- testbench/idv_checker_sva.sv
/* idv_checker_sva: port-level assertions for idv_top.
   Assumes it is bound onto idv_top; one clock, SRST synchronous. */
`timescale 1ns/1ns
module idv_checker_sva
	import idv_pkg::*;
(
	// clock and reset
	input wire logic                CORE_CLK,
	input wire logic                SRST,
	// register access
	input wire logic                REG_WR_EN,
	input wire logic                REG_RD_EN,
	input wire logic [15:0]         REG_ADDR,
	input wire logic [15:0]         REG_WR_DATA,
	input wire logic [15:0]         REG_RD_DATA,
	input wire logic                REG_RD_VALID,
	// samples
	input wire logic                IN_VALID,
	input wire logic                IN_READY,
	input wire logic [PATH_W-1:0]   IN_PATH,
	input wire logic [SAMPLE_W-1:0] IN_SAMPLE,
	input wire logic                OUT_VALID,
	input wire logic                OUT_READY,
	input wire logic [PATH_W-1:0]   OUT_PATH,
	input wire logic [SAMPLE_W-1:0] OUT_SAMPLE,
	// status
	input wire logic [NUM_PATHS-1:0] RAMP_BUSY
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	wire path_hit = REG_ADDR == ADDR_PATH1L || REG_ADDR == ADDR_PATH1R
		|| REG_ADDR == ADDR_PATH2;
	wire map_hit = path_hit || REG_ADDR == ADDR_RAMP_RATES;
	sequence s_rd;
		REG_RD_EN ##1 REG_RD_VALID;
	endsequence
	sequence s_idle;
		!REG_RD_VALID && REG_RD_DATA == 16'h0000;
	endsequence
	property p_rd_valid;
		REG_RD_EN |-> s_rd;
	endproperty
	property p_rd_idle;
		!REG_RD_EN |=> s_idle;
	endproperty
	property p_unmapped;
		REG_RD_EN && !map_hit |=> REG_RD_DATA == 16'h0000;
	endproperty
	property p_path_rsvd;
		REG_RD_EN && path_hit |=> REG_RD_DATA[15:9] == 7'h00;
	endproperty
	property p_rate_rsvd;
		REG_RD_EN && REG_ADDR == ADDR_RAMP_RATES
			|=> REG_RD_DATA[15:7] == 9'h000 && !REG_RD_DATA[3];
	endproperty
	property p_store_only;
		REG_WR_EN && !(path_hit && REG_WR_DATA[9]) && RAMP_BUSY == 3'h0
			|=> RAMP_BUSY == 3'h0;
	endproperty
	property p_out_hold;
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_SAMPLE)
			&& $stable(OUT_PATH);
	endproperty
	property p_path3;
		OUT_VALID && OUT_PATH == 2'h3 |-> OUT_SAMPLE == 24'h000000;
	endproperty
	property p_release;
		$fell(SRST) |-> !OUT_VALID && !REG_RD_VALID && IN_READY
			&& RAMP_BUSY == 3'h0;
	endproperty
	a_rd_valid: assert property (p_rd_valid)
		else $error("read not answered next cycle");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data without a read");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_path_rsvd: assert property (p_path_rsvd)
		else $error("apply or spare bits read nonzero");
	a_rate_rsvd: assert property (p_rate_rsvd)
		else $error("rate spare bits read nonzero");
	a_store_only: assert property (p_store_only)
		else $error("gain moved without apply");
	a_out_hold: assert property (p_out_hold)
		else $error("output changed while stalled");
	a_path3: assert property (p_path3)
		else $error("unused path not silent");
	a_release: assert property (p_release)
		else $error("outputs not idle after reset");
endmodule
bind idv_top idv_checker_sva u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST),
	.REG_WR_EN(REG_WR_EN), .REG_RD_EN(REG_RD_EN), .REG_ADDR(REG_ADDR),
	.REG_WR_DATA(REG_WR_DATA), .REG_RD_DATA(REG_RD_DATA),
	.REG_RD_VALID(REG_RD_VALID), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
	.IN_PATH(IN_PATH), .IN_SAMPLE(IN_SAMPLE), .OUT_VALID(OUT_VALID),
	.OUT_READY(OUT_READY), .OUT_PATH(OUT_PATH), .OUT_SAMPLE(OUT_SAMPLE),
	.RAMP_BUSY(RAMP_BUSY));

//--- testbench/test_input_digital_volume_ramp.sv
/* test_input_digital_volume_ramp: self-checking bench for idv_top.
   Assumes the bench alone drives every input; checker bound apart. */
`timescale 1ns/1ns
module test_input_digital_volume_ramp
	import idv_pkg::*;
;
	localparam int S2 = 4;
	localparam int S4 = 6;
	localparam int S8 = 8;
	logic                 clk, srst, wr_en, rd_en, in_valid, out_ready;
	logic [15:0]          addr, wdata, rd_data;
	logic [PATH_W-1:0]    in_path, out_path;
	logic [SAMPLE_W-1:0]  in_sample, out_sample;
	logic                 rd_valid, in_ready, out_valid, hold_out;
	logic [NUM_PATHS-1:0] busy;
	integer               seed = 32'hA013;
	int                   miscompares = 0;
	int                   check_count = 0;
	logic signed [31:0]   exq[$];
	logic [1:0]           pq[$];

	// short step counts keep ramps to a few thousand cycles
	idv_top #(.P_STEP_CYC_2(S2), .P_STEP_CYC_4(S4), .P_STEP_CYC_8(S8),
		.P_STEP_CYC_15(10), .P_STEP_CYC_30(12)) dut (.CORE_CLK(clk),
		.SRST(srst), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en), .REG_ADDR(addr),
		.REG_WR_DATA(wdata), .REG_RD_DATA(rd_data), .REG_RD_VALID(rd_valid),
		.IN_VALID(in_valid), .IN_READY(in_ready), .IN_PATH(in_path),
		.IN_SAMPLE(in_sample), .OUT_VALID(out_valid), .OUT_READY(out_ready),
		.OUT_PATH(out_path), .OUT_SAMPLE(out_sample), .RAMP_BUSY(busy));

	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	task automatic end_sim;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic signed [31:0] e, g,
		input int tol);
		check_count++;
		if ($isunknown(g) || g > e + tol || g < e - tol) begin
			miscompares++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	function automatic logic signed [31:0] gain_of(
		input logic signed [31:0] s, input int sh);
		logic signed [31:0] r;
		r = (sh >= 0) ? (s <<< sh) : (s >>> -sh);
		if (r > 32'sh7FFFFF) r = 32'sh7FFFFF;
		if (r < -32'sh800000) r = -32'sh800000;
		return r;
	endfunction

	// valid only for codes a whole number of 6 dB from 0 dB
	function automatic int shf(input logic [7:0] c);
		return (int'(c) - 128) / 12 + 1;
	endfunction

	task automatic wr(input logic [15:0] a, d);
		@(negedge clk);
		wr_en = 1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr_en = 0;
	endtask

	task automatic rd(input logic [15:0] a, e);
		@(negedge clk);
		rd_en = 1;
		addr = a;
		@(negedge clk);
		rd_en = 0;
		chk("rd_valid", 1, rd_valid, 0);
		chk("rd_data", e, rd_data, 0);
	endtask

	task automatic send(input logic [1:0] p, input logic [23:0] s,
		input logic signed [31:0] e);
		int k;
		@(negedge clk);
		in_valid = 1;
		in_path = p;
		in_sample = s;
		for (k = 0; k < 200 && in_ready !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		in_valid = 0;
		exq.push_back(e);
		pq.push_back(p);
	endtask

	task automatic burst(input logic [1:0] p, input logic [7:0] c,
		input bit m);
		logic [23:0] s;
		repeat (6) begin
			s = $random(seed);
			send(p, s, (m || p == 2'h3) ? 32'sh0 : gain_of($signed(s), shf(c)));
		end
	endtask

	// counts busy cycles per path until all ramps settle
	task automatic ramp(input int e0, e1, e2);
		int c[3] = '{0, 0, 0};
		int k;
		for (k = 0; k < 12000 && busy !== 3'h0; k++) begin
			for (int i = 0; i < 3; i++) c[i] += busy[i];
			@(negedge clk);
		end
		chk("busy0", e0, c[0], 2);
		chk("busy1", e1, c[1], 2);
		chk("busy2", e2, c[2], 2);
	endtask

	always @(negedge clk)
		out_ready <= hold_out ? 1'b0 : (($random(seed) & 3) != 0);

	always @(posedge clk) if (out_valid === 1'b1 && out_ready === 1'b1) begin
		chk("out_path", pq[0], out_path, 0);
		chk("out_sample", exq.pop_front(), $signed(out_sample), 1);
		void'(pq.pop_front());
	end

	initial begin
		#400000;
		miscompares++;
		end_sim;
	end

	initial begin
		logic [2:0]  r;
		logic [15:0] e;
		int          n;
		srst = 1;
		{wr_en, rd_en, in_valid, hold_out} = 4'h0;
		{addr, wdata} = 32'h0000_0000;
		in_path = 2'h0;
		in_sample = 24'h000000;
		repeat (8) @(negedge clk);
		srst = 0;
		rd(ADDR_RAMP_RATES, 16'h0022);
		rd(ADDR_PATH1L, 16'h0180);
		rd(ADDR_PATH1R, 16'h0180);
		rd(ADDR_PATH2, 16'h0180);
		wr(16'h0310, 16'h0000);
		rd(16'h0310, 16'h0000);
		for (int c = 0; c < 8; c++) begin
			r = 3'(c);
			e = {9'h000, r, 1'b0, r};
			wr(ADDR_RAMP_RATES, 16'hFF88 | e);
			rd(ADDR_RAMP_RATES, e);
		end
		wr(ADDR_RAMP_RATES, 16'h0043);
		wr(ADDR_PATH1L, 16'h0044);
		repeat (20) @(negedge clk);
		chk("busy", 0, busy, 0);
		rd(ADDR_PATH1L, 16'h0044);
		wr(ADDR_PATH2, 16'h0280);
		ramp(16'h44 * 4 * S2, 0, 512 * S2);
		rd(ADDR_PATH2, 16'h0080);
		burst(0, 8'h44, 0);
		burst(1, 8'h80, 1);
		burst(2, 8'h80, 0);
		burst(3, 8'h80, 1);
		send(2, 24'h3FFFFF, 32'sh7FFFFE);
		send(2, 24'h400000, 32'sh7FFFFF);
		wr(ADDR_PATH1L, 16'h0238);
		ramp(48 * S4, 0, 0);
		wr(ADDR_RAMP_RATES, 16'h0045);
		wr(ADDR_PATH1L, 16'h0244);
		ramp(48 * S8, 0, 0);
		wr(ADDR_RAMP_RATES, 16'h0000);
		wr(ADDR_PATH2, 16'h0380);
		ramp(0, 0, 0);
		burst(2, 8'h80, 1);
		wr(ADDR_PATH2, 16'h0274);
		ramp(0, 0, 0);
		burst(2, 8'h74, 0);
		wr(ADDR_RAMP_RATES, 16'h0067);
		wr(ADDR_PATH1L, 16'h0246);
		ramp(8 * 12, 0, 0);
		wr(ADDR_PATH1L, 16'h0244);
		ramp(8 * 10, 0, 0);
		wr(ADDR_RAMP_RATES, 16'h0021);
		wr(ADDR_PATH1L, 16'h0245);
		ramp(4 * STEP_CYC_0P5, 0, 0);
		wr(ADDR_PATH1L, 16'h0244);
		ramp(4 * STEP_CYC_1, 0, 0);
		burst(0, 8'h44, 0);
		wr(ADDR_PATH1R, 16'h00C5);
		rd(ADDR_PATH1R, 16'h00C5);
		for (n = 0; n < 100 && exq.size() != 0; n++) @(negedge clk);
		hold_out = 1;
		n = 0;
		while (in_ready === 1'b1 && n < 40) begin
			send(2, 24'(n * 16), n * 16);
			n++;
		end
		// fifo words plus the held output register
		chk("accepted", 33, n, 1);
		hold_out = 0;
		for (n = 0; n < 300 && exq.size() != 0; n++) @(negedge clk);
		chk("pending", 0, exq.size(), 0);
		end_sim;
	end
endmodule
